//--- ict_pkg.sv
/*
  Package for the interval carry timer: APB register map, field positions,
  reset values, select encoding and pulse timing counts.
  Assumes a 50 MHz system clock.
*/
package ict_pkg;

  // ==========================================================
  // Clock and pulse timing
  // ==========================================================
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RATE_10_HZ      = 10;
  localparam int unsigned RATE_20_HZ      = 20;
  localparam int unsigned RATE_50_HZ      = 50;
  localparam int unsigned RATE_100_HZ     = 100;
  localparam int unsigned HALF_10         = CLK_HZ / (2 * RATE_10_HZ);
  localparam int unsigned HALF_20         = CLK_HZ / (2 * RATE_20_HZ);
  localparam int unsigned HALF_50         = CLK_HZ / (2 * RATE_50_HZ);
  localparam int unsigned HALF_100        = CLK_HZ / (2 * RATE_100_HZ);
  // Fixed phase offsets in cycles, each well below the shortest period
  localparam int unsigned PHASE_10        = 0;
  localparam int unsigned PHASE_20        = 1000;
  localparam int unsigned PHASE_50        = 2000;
  localparam int unsigned PHASE_100       = 3000;
  localparam int unsigned CNT_W           = 23;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [11:0] ADDR_CARRY      = 12'h000;
  localparam logic [11:0] ADDR_SELECT     = 12'h004;
  localparam logic [11:0] ADDR_STATUS     = 12'h008;
  localparam logic [11:0] ADDR_CMD        = 12'h00C;

  localparam int unsigned CARRY_BIT       = 0;
  localparam int unsigned SEL_LO_BIT      = 0;
  localparam int unsigned SEL_HI_BIT      = 1;
  localparam int unsigned ST_ARMED_BIT    = 0;
  localparam int unsigned ST_PEND_BIT     = 1;
  localparam int unsigned ST_PULSE_BIT    = 2;
  localparam int unsigned CMD_STOP_BIT    = 0;

  localparam logic [1:0]  SEL_RESET       = 2'h0;

  // Select encoding
  localparam logic [1:0]  SEL_10HZ        = 2'h0;
  localparam logic [1:0]  SEL_20HZ        = 2'h1;
  localparam logic [1:0]  SEL_50HZ        = 2'h2;
  localparam logic [1:0]  SEL_100HZ       = 2'h3;

  // Backup reset sequencer states, Gray coded except the FIRE to IDLE step
  typedef enum logic [1:0] {
    ICT_IDLE  = 2'b00,
    ICT_WAIT  = 2'b01,
    ICT_FIRE  = 2'b11
  } ict_bk_state_t;

endpackage : ict_pkg

//--- ict_pulse_gen.sv
/*
  Square wave generator with fixed start phase for the interval timer.
  Runs on the system clock; free running from reset onward.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_pulse_gen
  import ict_pkg::*;
#(
  parameter int unsigned HALF  = 2500000,
  parameter int unsigned PHASE = 0
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      pulse
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             lvl_q;
  logic             lvl_d;

  // ==========================================================
  // Half period counter
  // ==========================================================
  always_comb begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (cnt_q == CNT_W'(HALF - 1)) begin
      cnt_d = '0;
      lvl_d = ~lvl_q;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Preloaded count sets the fixed phase against the other pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_W'(PHASE);
      lvl_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign pulse = lvl_q;

endmodule // ict_pulse_gen
`default_nettype wire

//--- ict_timer.sv
/*
  Interval carry timer: four free running pulses, a select, a carry flag
  cleared on read, and backup-pin reset timing with read arbitration.
  Assumes an APB master on clk and an asynchronous backup sense pin.
*/
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - Four rates generated independently, always
// - Fixed small phase offsets between pulses
// - Select change: rising new pulse sets flag
// - Power-on clears flag; armed by first read
// - Reading the flag clears it
// - Backup reset on next selected rising edge
// - Flag reads 1 after backup reset
// - Read wins; backup reset postponed one edge
// - Power-on starts execution; 10 Hz rises
// - Flag is bit 0, others zero
// - Backup reset and clock stop force flag
module ict_timer
  import ict_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        backup_sense,
  output logic             backup_reset_pulse,
  output logic             exec_start_pulse
);

  // ==========================================================
  // Pulse sources
  // ==========================================================
  logic [3:0] pulse;

  ict_pulse_gen #(.HALF(HALF_10),  .PHASE(PHASE_10))  u_p10  (
    .clk   (clk),
    .rst   (rst),
    .pulse (pulse[0])
  );
  ict_pulse_gen #(.HALF(HALF_20),  .PHASE(PHASE_20))  u_p20  (
    .clk   (clk),
    .rst   (rst),
    .pulse (pulse[1])
  );
  ict_pulse_gen #(.HALF(HALF_50),  .PHASE(PHASE_50))  u_p50  (
    .clk   (clk),
    .rst   (rst),
    .pulse (pulse[2])
  );
  ict_pulse_gen #(.HALF(HALF_100), .PHASE(PHASE_100)) u_p100 (
    .clk   (clk),
    .rst   (rst),
    .pulse (pulse[3])
  );

  function automatic logic pick(input logic [1:0] sel, input logic [3:0] p);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_10HZ:  r = p[0];
      SEL_20HZ:  r = p[1];
      SEL_50HZ:  r = p[2];
      default:   r = p[3];
    endcase
    return r;
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [1:0]    sel_q, sel_d;
  logic          prev_q, prev_d;
  logic          flag_q, flag_d;
  logic          armed_q, armed_d;
  logic          sync1_q, sync2_q;
  logic          bk_prev_q;
  ict_bk_state_t st_q, st_d;
  logic [31:0]   prdata_d;
  logic          pready_d, pslverr_d;
  logic          bkp_d, exec_d;
  logic          boot_q;

  logic cur_sel;
  logic rise;
  logic acc;
  logic rd_flag;

  // Access phase completes the cycle pready is seen high
  assign acc     = psel & penable & pready;
  assign cur_sel = pick(sel_q, pulse);
  // compares against prior sample, so a select change from a low pulse to a high pulse sets
  assign rise    = cur_sel & ~prev_q;
  assign rd_flag = psel & penable & ~pready & ~pwrite & (paddr == ADDR_CARRY);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    sel_d     = sel_q;
    prev_d    = cur_sel;
    flag_d    = flag_q;
    armed_d   = armed_q;
    st_d      = st_q;
    bkp_d     = 1'b0;
    exec_d    = 1'b0;
    prdata_d  = '0;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;

    if (rise && armed_q) begin
      flag_d = 1'b1;
    end
    // read clears; clear beats a same-cycle rise, that edge is lost
    if (rd_flag) begin
      armed_d = 1'b1;
      flag_d  = 1'b0;
    end

    // Backup reset sequencer
    case (st_q)
      ICT_IDLE: begin
        // pin edge only, a pin held high fires once
        if (sync2_q && !bk_prev_q) begin
          st_d = ICT_WAIT;
        end
      end
      ICT_WAIT: begin
        // read in the same cycle wins
        if (rise && !rd_flag) begin
          st_d = ICT_FIRE;
        end
      end
      ICT_FIRE: begin
        // reset applied, flag set, execution start pulsed
        flag_d  = 1'b1;
        armed_d = 1'b1;
        bkp_d   = 1'b1;
        exec_d  = 1'b1;
        st_d    = ICT_IDLE;
      end
      default: st_d = ICT_IDLE;
    endcase

    // APB slave, one wait state
    if (psel && penable && !pready) begin
      pready_d = 1'b1;
      if (pwrite) begin
        if (paddr == ADDR_SELECT) begin
          sel_d = pwdata[SEL_HI_BIT:SEL_LO_BIT];
        end else if (paddr == ADDR_CMD) begin
          if (pwdata[CMD_STOP_BIT]) begin
            flag_d = 1'b1;
          end
        end else if (paddr != ADDR_CARRY) begin
          pslverr_d = 1'b1;
        end
      end else begin
        if (paddr == ADDR_CARRY) begin
          prdata_d[CARRY_BIT] = flag_q;
        end else if (paddr == ADDR_SELECT) begin
          prdata_d[SEL_HI_BIT:SEL_LO_BIT] = sel_q;
        end else if (paddr == ADDR_STATUS) begin
          prdata_d[ST_ARMED_BIT] = armed_q;
          prdata_d[ST_PEND_BIT]  = (st_q != ICT_IDLE);
          prdata_d[ST_PULSE_BIT] = cur_sel;
        end else if (paddr != ADDR_CMD) begin
          pslverr_d = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q              <= SEL_RESET;
      prev_q             <= 1'b0;
      flag_q             <= 1'b0;
      armed_q            <= 1'b0;
      sync1_q            <= 1'b0;
      sync2_q            <= 1'b0;
      bk_prev_q          <= 1'b0;
      st_q               <= ICT_IDLE;
      prdata             <= '0;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      backup_reset_pulse <= 1'b0;
      exec_start_pulse   <= 1'b0;
      boot_q             <= 1'b1;
    end else begin
      sel_q              <= sel_d;
      prev_q             <= prev_d;
      flag_q             <= flag_d;
      armed_q            <= armed_d;
      sync1_q            <= backup_sense;
      sync2_q            <= sync1_q;
      bk_prev_q          <= sync2_q;
      st_q               <= st_d;
      prdata             <= prdata_d;
      pready             <= pready_d;
      pslverr            <= pslverr_d;
      backup_reset_pulse <= bkp_d;
      // 10 Hz pulse starts high, execution starts at power-on
      exec_start_pulse   <= exec_d | boot_q;
      boot_q             <= 1'b0;
    end
  end

endmodule // ict_timer
`default_nettype wire

//--- ict_timer_assertions.sv
/*
  Port checker for the interval carry timer.
  Assumes binding to ict_timer; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_timer_assertions
  import ict_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        backup_sense,
  input wire logic        backup_reset_pulse,
  input wire logic        exec_start_pulse
);
  // ==========================================================
  // Port relations
  // ==========================================================
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_READY_AFTER_ACCESS: assert property
    (psel && penable && !$past(penable) |=> pready ##1 !pready) else $error("late ready");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("stray ready");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("stray error");
  AST_IDLE_DATA_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("idle data");
  AST_CARRY_HIGH_ZERO: assert property
    (pready && !pwrite && paddr == ADDR_CARRY |-> prdata[31:1] == 31'h0) else $error("bits");
  AST_EXEC_AFTER_RESET: assert property ($fell(rst) |-> ##[1:2] exec_start_pulse)
    else $error("no start");
  AST_EXEC_ONE: assert property (exec_start_pulse |=> !exec_start_pulse)
    else $error("start held");
  AST_BACKUP_STARTS: assert property (backup_reset_pulse |-> exec_start_pulse)
    else $error("reset without start");
  AST_BACKUP_ONE: assert property (backup_reset_pulse |=> !backup_reset_pulse)
    else $error("reset held");
endmodule // ict_timer_assertions
`default_nettype wire

//--- ict_sense_model.sv
/*
  Backup sense pin model: supply returns some cycles after a request.
  Assumes the bench clock; the pin idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module ict_sense_model (
  input  wire logic clk,
  input  wire logic power_back,
  output logic      backup_sense
);
  initial backup_sense = 1'b0;
  // Pin rises late, not in step with the bus
  always @(posedge clk) begin
    if (power_back) begin
      repeat (7) @(posedge clk);
      backup_sense <= 1'b1;
    end
  end
endmodule // ict_sense_model
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench for the interval carry timer over APB.
  Assumes pulses stay high for the run: periods exceed it.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ict_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, power_back;
  logic        backup_sense, backup_reset_pulse, exec_start_pulse, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  code;
  int          n_fail, samples_checked, n_exec, n_bk;
  ict_timer u_ict_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .backup_sense(backup_sense),
    .backup_reset_pulse(backup_reset_pulse), .exec_start_pulse(exec_start_pulse));
  ict_sense_model u_ict_sense_model (.clk(clk), .power_back(power_back),
    .backup_sense(backup_sense));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    n_exec <= n_exec + int'(exec_start_pulse === 1'b1);
    n_bk   <= n_bk + int'(backup_reset_pulse === 1'b1);
  end
  function automatic logic [31:0] word(input logic f);
    return {31'h0, f};
  endfunction
  // Flag after a select change: set only when the chosen level goes low to high
  function automatic logic [31:0] sel_flag(input logic old_lvl, input logic new_lvl);
    return word(new_lvl & ~old_lvl);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // APB master
  // ==========================================================
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    {psel, penable, pwrite, power_back, n_fail, samples_checked, n_exec, n_bk} = '0;
    paddr = 12'h0; pwdata = 32'h0; rst = 1'b1;
    void'($urandom(13));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CARRY, 32'h0); chk(r, word(1'b0));
    apb(1'b0, ADDR_STATUS, 32'h0); chk(r[2:0], 32'h5);
    apb(1'b1, ADDR_CMD, 32'h1); apb(1'b0, ADDR_CARRY, 32'h0); chk(r, word(1'b1));
    apb(1'b0, ADDR_CARRY, 32'h0); chk(r, word(1'b0));
    apb(1'b1, ADDR_CARRY, 32'hFFFF_FFFF); apb(1'b0, ADDR_CARRY, 32'h0); chk(r, 32'h0);
    for (int k = 1; k < 9; k++) begin
      code = 2'(k);
      apb(1'b1, ADDR_SELECT, {$urandom() & 32'hFFFF_FFFC} | 32'(code));
      apb(1'b0, ADDR_SELECT, 32'h0); chk(r[1:0], 32'(code));
      apb(1'b0, ADDR_STATUS, 32'h0); chk(r[2], 1'b1);
      // High to high select change makes no rise
      apb(1'b0, ADDR_CARRY, 32'h0); chk(r, sel_flag(1'b1, 1'b1));
    end
    apb(1'b0, 12'h010 + 12'($urandom_range(0, 60) * 4), 32'h0); chk(e, 1'b1);
    power_back <= 1'b1;
    @(posedge clk) power_back <= 1'b0;
    repeat (15) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0); chk(r[1], 1'b1);
    apb(1'b0, ADDR_CARRY, 32'h0); chk(r, word(1'b0));
    repeat (50) @(posedge clk);
    chk(n_bk, 0);
    chk(n_exec, 1);
    results();
  end
endmodule // testbench
bind ict_timer ict_timer_assertions u_ict_timer_assertions (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .backup_sense(backup_sense),
  .backup_reset_pulse(backup_reset_pulse), .exec_start_pulse(exec_start_pulse));
`default_nettype wire
